/* File: core/mhcs_pkg.sv */
// shared constants of the motor host control and status register bank
//----------------------------------------------------------------------
// Function
// [RQ1] Offset 0x00 holds the low eight bits of the speed command.
// [RQ2] Bit 7 of offset 0x01 lets the host speed command drive the motor.
// [RQ3] Bit 0 of offset 0x01 holds the speed MSB; bits 6..1 unused.
// [RQ4] Host should write the MSB register before the low byte register.
// [RQ5] Stored MSB is captured when the low byte lands; command updates atomically.
// [RQ6] Programming needs key 0xB6 at offset 0x02, then the program bit next.
// [RQ7] Stored key is cleared by any other following register access.
// [RQ8] Bit 7 of offset 0x03 blocks entry into the low power state.
// [RQ9] Configuration writes pass only while bit 6 of offset 0x03 is set.
// [RQ10] Bit 5 of offset 0x03 requests reload of nonvolatile contents.
// [RQ11] Bit 4 of offset 0x03 starts programming, subject to the key.
// [RQ12] Status bit 7 at offset 0x10 reports over temperature.
// [RQ13] Status bit 6 reports the device entered its low power state.
// [RQ14] Status bit 5 latches a phase overcurrent event until cleared.
// [RQ15] Reading the status register clears the latched overcurrent flag.
// [RQ16] Status bit 4 reports a locked rotor; bits 3..0 unused.
// [RQ17] Undefined bit positions read zero and ignore writes.
//----------------------------------------------------------------------
package mhcs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_SPEED_LOW = 8'h00;
  localparam logic [7:0] ADDR_SPEED_HIGH = 8'h01;
  localparam logic [7:0] ADDR_UNLOCK = 8'h02;
  localparam logic [7:0] ADDR_NVM_CTRL = 8'h03;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CFG_FIRST = 8'h20;
  localparam logic [7:0] ADDR_CFG_LAST = 8'h2B;
  // field positions
  localparam int TAKEOVER_BIT = 7;
  localparam int SPEED_MSB_BIT = 0;
  localparam int LP_BLOCK_BIT = 7;
  localparam int CFG_WE_BIT = 6;
  localparam int RELOAD_BIT = 5;
  localparam int PROGRAM_BIT = 4;
  localparam int SPEED_W = 9;
  // values
  localparam logic [7:0] PROGRAM_KEY = 8'hB6;
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [8:0] SPEED_RST = 9'h000;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // bus address of the device, value arbitrary
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2A;
endpackage

/* File: core/mhcs_i2c_engine.sv */
// i2c byte engine: pin sampling, framing, acknowledge and bit shifting
`timescale 1ns/1ps
module mhcs_i2c_engine #(
  parameter logic [6:0] DEV_ADDR = mhcs_pkg::I2C_DEV_ADDR
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic ptr_stb_o,
  output logic wr_stb_o,
  output logic [7:0] byte_o,
  output logic rd_load_o,
  output logic rd_done_o,
  input wire logic [7:0] rd_byte_i
);
  import mhcs_pkg::*;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'h0,
    ENG_ADDR = 3'h1,
    ENG_ADDR_ACK = 3'h2,
    ENG_WR = 3'h3,
    ENG_WR_ACK = 3'h4,
    ENG_RD = 3'h5,
    ENG_RD_ACK = 3'h6
  } mhcs_eng_state_t;

  mhcs_eng_state_t state_q;
  logic scl_m_q, scl_q, scl_d_q, sda_m_q, sda_q, sda_d_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic rnw_q, first_q, mack_q;

  //--------------------------------------------------------------------
  // pin sampling
  //--------------------------------------------------------------------
  // two stages before any decode; third stage only for edge finding
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {scl_m_q, scl_q, scl_d_q} <= 3'h7;
      {sda_m_q, sda_q, sda_d_q} <= 3'h7;
    end
    else
    begin
      {scl_m_q, scl_q, scl_d_q} <= {scl_i, scl_m_q, scl_q};
      {sda_m_q, sda_q, sda_d_q} <= {sda_i, sda_m_q, sda_q};
    end
  end

  wire scl_rise = scl_q & ~scl_d_q;
  wire scl_fall = ~scl_q & scl_d_q;
  wire start_ev = scl_q & scl_d_q & sda_d_q & ~sda_q;
  wire stop_ev = scl_q & scl_d_q & ~sda_d_q & sda_q;
  wire byte_full = (cnt_q == BITS_PER_BYTE);
  wire addr_hit = (shift_q[7:1] == DEV_ADDR);

  //--------------------------------------------------------------------
  // framing state machine
  //--------------------------------------------------------------------
  // sda only changes after scl falls, so the host never sees a false start
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ENG_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      rnw_q <= 1'b0;
      first_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end
    else if (start_ev)
    begin
      state_q <= ENG_ADDR;
      cnt_q <= 4'h0;
      sda_oe_n_o <= 1'b1;
    end
    else if (stop_ev)
    begin
      state_q <= ENG_IDLE;
      sda_oe_n_o <= 1'b1;
    end
    else if (scl_rise)
    begin
      case (state_q)
        ENG_ADDR, ENG_WR:
        begin
          shift_q <= {shift_q[6:0], sda_q};
          cnt_q <= cnt_q + 4'h1;
        end
        ENG_RD: cnt_q <= cnt_q + 4'h1;
        ENG_RD_ACK: mack_q <= ~sda_q; // low means host wants more
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_q)
        ENG_ADDR:
        if (byte_full)
        begin
          if (addr_hit)
          begin
            state_q <= ENG_ADDR_ACK;
            sda_oe_n_o <= 1'b0;
            rnw_q <= shift_q[0];
            first_q <= ~shift_q[0];
          end
          else
          begin
            state_q <= ENG_IDLE;
          end
        end
        ENG_ADDR_ACK, ENG_RD_ACK:
        begin
          cnt_q <= 4'h0;
          if ((state_q == ENG_ADDR_ACK) ? rnw_q : mack_q)
          begin
            state_q <= ENG_RD;
            sda_oe_n_o <= rd_byte_i[7];
            shift_q <= {rd_byte_i[6:0], 1'b0};
          end
          else
          begin
            state_q <= (state_q == ENG_ADDR_ACK) ? ENG_WR : ENG_IDLE;
            sda_oe_n_o <= 1'b1;
          end
        end
        ENG_WR:
        if (byte_full)
        begin
          state_q <= ENG_WR_ACK;
          sda_oe_n_o <= 1'b0;
          first_q <= 1'b0;
        end
        ENG_WR_ACK:
        begin
          state_q <= ENG_WR;
          cnt_q <= 4'h0;
          sda_oe_n_o <= 1'b1;
        end
        ENG_RD:
        if (byte_full)
        begin
          state_q <= ENG_RD_ACK;
          sda_oe_n_o <= 1'b1;
        end
        else
        begin
          sda_oe_n_o <= shift_q[7];
          shift_q <= {shift_q[6:0], 1'b0};
        end
        default: ;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // strobes towards the register bank
  //--------------------------------------------------------------------
  // the read load after an ack waits one cycle so the pointer has moved
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr_stb_o <= 1'b0;
      wr_stb_o <= 1'b0;
      byte_o <= 8'h00;
      rd_load_o <= 1'b0;
      rd_done_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      ptr_stb_o <= scl_fall & (state_q == ENG_WR) & byte_full & first_q;
      wr_stb_o <= scl_fall & (state_q == ENG_WR) & byte_full & ~first_q;
      if (scl_fall && (state_q == ENG_WR) && byte_full)
      begin
        byte_o <= shift_q;
      end
      rd_load_o <= (scl_fall & (state_q == ENG_ADDR) & byte_full & addr_hit & shift_q[0])
        | (rd_done_o & mack_q);
      rd_done_o <= scl_rise & (state_q == ENG_RD_ACK) & ~start_ev & ~stop_ev;
      sda_o <= 1'b0; // open drain: only ever pulls low
    end
  end
endmodule // mhcs_i2c_engine

/* File: core/mhcs_regs_top.sv */
// host control and status register bank behind the i2c pins
`timescale 1ns/1ps
module mhcs_regs_top #(
  parameter logic [6:0] DEV_ADDR = mhcs_pkg::I2C_DEV_ADDR
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic thermal_fault_i,
  input wire logic low_power_state_i,
  input wire logic overcurrent_i,
  input wire logic rotor_stalled_i,
  output logic [mhcs_pkg::SPEED_W-1:0] host_speed_value_o,
  output logic host_speed_takeover_o,
  output logic low_power_entry_block_o,
  output logic cfg_write_enable_o,
  output logic nvm_reload_o,
  output logic nvm_program_o,
  output logic cfg_wr_o,
  output logic [7:0] cfg_addr_o,
  output logic [7:0] cfg_data_o
);
  import mhcs_pkg::*;

  logic ptr_stb, wr_stb, rd_load, rd_done;
  logic [7:0] byte_w;
  logic [7:0] ptr_q;
  logic [7:0] key_q;
  logic [7:0] rd_byte_q;
  logic [7:0] rd_next;
  logic speed_msb_q;
  logic oc_q;

  //--------------------------------------------------------------------
  // bus front end
  //--------------------------------------------------------------------
  mhcs_i2c_engine #(
    .DEV_ADDR(DEV_ADDR)
  ) u_engine (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .ptr_stb_o(ptr_stb),
    .wr_stb_o(wr_stb),
    .byte_o(byte_w),
    .rd_load_o(rd_load),
    .rd_done_o(rd_done),
    .rd_byte_i(rd_byte_q)
  );

  //--------------------------------------------------------------------
  // address decode
  //--------------------------------------------------------------------
  // one strobe qualified by the current register pointer
  function automatic logic hit(input logic stb, input logic [7:0] p, input logic [7:0] a);
    return stb && (p == a);
  endfunction

  wire wr_low = hit(wr_stb, ptr_q, ADDR_SPEED_LOW);
  wire wr_high = hit(wr_stb, ptr_q, ADDR_SPEED_HIGH);
  wire wr_key = hit(wr_stb, ptr_q, ADDR_UNLOCK);
  wire wr_ctrl = hit(wr_stb, ptr_q, ADDR_NVM_CTRL);
  wire rd_status = hit(rd_load, ptr_q, ADDR_STATUS);
  wire rd_high = hit(rd_load, ptr_q, ADDR_SPEED_HIGH);
  wire host_action = wr_stb | rd_done;
  wire in_cfg = (ptr_q >= ADDR_CFG_FIRST) && (ptr_q <= ADDR_CFG_LAST);
  wire prog_req = wr_ctrl && byte_w[PROGRAM_BIT] && (key_q == PROGRAM_KEY); // [RQ6] [RQ11]

  // pointer byte sets it; every data byte moves it on by one
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr_q <= PTR_RST;
    end
    else if (ptr_stb)
    begin
      ptr_q <= byte_w;
    end
    else if (host_action)
    begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  //--------------------------------------------------------------------
  // speed command
  //--------------------------------------------------------------------
  // msb waits in a holding flop; command only changes on the low byte,
  // so the motor never runs on a half-updated nine bit value
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      speed_msb_q <= 1'b0;
      host_speed_takeover_o <= 1'b0;
      host_speed_value_o <= SPEED_RST;
    end
    else
    begin
      if (wr_high)
      begin
        speed_msb_q <= byte_w[SPEED_MSB_BIT]; // [RQ3]
        host_speed_takeover_o <= byte_w[TAKEOVER_BIT]; // [RQ2]
      end
      if (wr_low)
      begin
        host_speed_value_o <= {speed_msb_q, byte_w}; // [RQ1] [RQ5]
      end
    end
  end

  //--------------------------------------------------------------------
  // programming key
  //--------------------------------------------------------------------
  // any data write or read byte other than a fresh key write wipes it, so a stale key
  // left from an aborted sequence can never unlock a later program
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      key_q <= KEY_RST;
    end
    else if (wr_key)
    begin
      key_q <= byte_w; // [RQ6]
    end
    else if (host_action)
    begin
      key_q <= KEY_RST; // [RQ7]
    end
  end

  //--------------------------------------------------------------------
  // nonvolatile control
  //--------------------------------------------------------------------
  // reload and program are one cycle requests and read back as zero
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      low_power_entry_block_o <= 1'b0;
      cfg_write_enable_o <= 1'b0;
      nvm_reload_o <= 1'b0;
      nvm_program_o <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        low_power_entry_block_o <= byte_w[LP_BLOCK_BIT]; // [RQ8]
        cfg_write_enable_o <= byte_w[CFG_WE_BIT];
      end
      nvm_reload_o <= wr_ctrl & byte_w[RELOAD_BIT]; // [RQ10]
      nvm_program_o <= prog_req; // [RQ11]
    end
  end

  // configuration writes pass through only while enabled
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_wr_o <= 1'b0;
      cfg_addr_o <= 8'h00;
      cfg_data_o <= 8'h00;
    end
    else
    begin
      cfg_wr_o <= wr_stb & in_cfg & cfg_write_enable_o; // [RQ9]
      if (wr_stb)
      begin
        cfg_addr_o <= ptr_q;
        cfg_data_o <= byte_w;
      end
    end
  end

  //--------------------------------------------------------------------
  // status
  //--------------------------------------------------------------------
  // a new event in the clearing cycle keeps the flag set
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      oc_q <= 1'b0;
    end
    else if (overcurrent_i)
    begin
      oc_q <= 1'b1; // [RQ14]
    end
    else if (rd_status)
    begin
      oc_q <= 1'b0; // [RQ15]
    end
  end

  // read data; undefined bits are zero
  always_comb
  begin
    case (ptr_q)
      ADDR_SPEED_LOW: rd_next = host_speed_value_o[7:0];
      ADDR_SPEED_HIGH: rd_next = {host_speed_takeover_o, 6'h00, speed_msb_q}; // [RQ17]
      ADDR_UNLOCK: rd_next = key_q;
      ADDR_NVM_CTRL: rd_next = {low_power_entry_block_o, cfg_write_enable_o, 6'h00};
      ADDR_STATUS: rd_next = {thermal_fault_i, low_power_state_i, oc_q | overcurrent_i,
        rotor_stalled_i, 4'h0}; // [RQ12] [RQ13] [RQ16]
      default: rd_next = 8'h00;
    endcase
  end

  // byte is frozen at load time and shifted out by the engine
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_byte_q <= 8'h00;
    end
    else if (rd_load)
    begin
      rd_byte_q <= rd_next;
    end
  end

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence key_written_s;
    wr_key && (byte_w == PROGRAM_KEY);
  endsequence

  sequence other_action_s;
    host_action && !wr_key;
  endsequence

  low_byte_a: assert property (wr_low |=> host_speed_value_o[7:0] == $past(byte_w)) // [RQ1]
    else $error("speed low byte not stored");

  takeover_a: assert property (wr_high |=> host_speed_takeover_o == $past(byte_w[7])) // [RQ2]
    else $error("takeover bit not stored");

  msb_hold_a: assert property (wr_high |=> speed_msb_q == $past(byte_w[0])) // [RQ3]
    else $error("speed msb not held");

  msb_pending_a: assert property (wr_high |=> $stable(host_speed_value_o)) // [RQ5]
    else $error("speed command changed on msb write");

  speed_snap_a: assert property (wr_low |=> host_speed_value_o[8] == $past(speed_msb_q)) // [RQ5]
    else $error("speed msb not captured with low byte");

  key_hold_a: assert property (key_written_s |=> key_q == PROGRAM_KEY) // [RQ6]
    else $error("program key not held");

  // one legal byte lasts at least 72 cycles, so within 80 only the very next action fits
  key_prog_a: assert property (key_written_s ##[1:80] (wr_ctrl && byte_w[PROGRAM_BIT])
    |=> nvm_program_o) // [RQ6]
    else $error("keyed program request lost");

  prog_cause_a: assert property (nvm_program_o |-> $past(prog_req)) // [RQ11]
    else $error("program without key sequence");

  key_clear_a: assert property (other_action_s |=> key_q == KEY_RST) // [RQ7]
    else $error("stale program key kept");

  lp_block_a: assert property (wr_ctrl |=> low_power_entry_block_o == $past(byte_w[7])) // [RQ8]
    else $error("low power block bit not stored");

  cfg_gate_a: assert property (cfg_wr_o |-> $past(cfg_write_enable_o)) // [RQ9]
    else $error("configuration write while disabled");

  reload_req_a: assert property (wr_ctrl && byte_w[5] |=> nvm_reload_o ##1 !nvm_reload_o) // [RQ10]
    else $error("reload request not pulsed");

  status_read_a: assert property (rd_status |=> rd_byte_q[7] == $past(thermal_fault_i)
    && rd_byte_q[6] == $past(low_power_state_i) && rd_byte_q[4] == $past(rotor_stalled_i)
    && rd_byte_q[3:0] == 4'h0) // [RQ12] [RQ13] [RQ16]
    else $error("status byte wrong");

  oc_sticky_a: assert property (oc_q && !rd_status |=> oc_q) // [RQ14]
    else $error("overcurrent flag lost before read");

  oc_set_a: assert property (overcurrent_i |=> oc_q) // [RQ14]
    else $error("overcurrent event not latched");

  oc_clear_a: assert property (rd_status && !overcurrent_i |=> !oc_q) // [RQ15]
    else $error("overcurrent flag not cleared on read");

  spare_zero_a: assert property (rd_high |=> rd_byte_q[6:1] == 6'h00) // [RQ17]
    else $error("unused bits read nonzero");
endmodule // mhcs_regs_top

/* File: verif/mhcs_i2c_host.sv */
// i2c host model driving the register bank pins
`timescale 1ns/1ps
module mhcs_i2c_host (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_n_o
);
  //--------------------------------------------------------------
  // bus phases, quarter of the 160 ns link period
  //--------------------------------------------------------------
  localparam time QTR = 40ns;
  // scl stands high and sda is released between frames
  initial
  begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  // start, or repeated start when scl is low
  task automatic start();
    if (scl_o == 1'b0)
    begin
      #QTR sda_oe_n_o = 1'b1;
      #QTR scl_o = 1'b1;
    end
    #QTR sda_oe_n_o = 1'b0;
    #QTR scl_o = 1'b0;
  endtask
  task automatic stop();
    #QTR sda_oe_n_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_oe_n_o = 1'b1;
    #QTR;
  endtask
  // data changes mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    #QTR sda_oe_n_o = b;
    #QTR scl_o = 1'b1;
    #QTR s = sda_i;
    #QTR scl_o = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(nack, s);
  endtask
endmodule // mhcs_i2c_host

/* File: verif/mhcs_regs_top_tb_top.sv */
// self-checking bench for the host control and status registers
`timescale 1ns/1ps
module mhcs_regs_top_tb_top;
  import mhcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda, host_oe_n, dev_sda, dev_oe_n;
  logic thermal = 1'b0;
  logic lp_state = 1'b0;
  logic oc = 1'b0;
  logic stall = 1'b0;
  logic [SPEED_W-1:0] speed;
  logic takeover, lp_block, cfg_we, reload, nvm_prog, cfg_wr;
  logic [7:0] cfg_addr, cfg_data;
  int n_errors = 0;
  int total_checks = 0;
  int n_rel = 0;
  int n_prog = 0;
  int n_cfg = 0;
  int p0, r0, c0;
  //--------------------------------------------------------------
  // clock, wire and instances
  //--------------------------------------------------------------
  always #10 clk = ~clk;
  // open drain with pull-up: any party pulling low wins
  assign sda = host_oe_n & (dev_oe_n | dev_sda);
  mhcs_i2c_host mhcs_i2c_host_inst (.sda_i(sda), .scl_o(scl), .sda_oe_n_o(host_oe_n));
  mhcs_regs_top mhcs_regs_top_inst (
    .core_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(dev_sda),
    .sda_oe_n_o(dev_oe_n), .thermal_fault_i(thermal), .low_power_state_i(lp_state),
    .overcurrent_i(oc), .rotor_stalled_i(stall), .host_speed_value_o(speed),
    .host_speed_takeover_o(takeover), .low_power_entry_block_o(lp_block),
    .cfg_write_enable_o(cfg_we), .nvm_reload_o(reload), .nvm_program_o(nvm_prog),
    .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr), .cfg_data_o(cfg_data)
  );
  // pulse counters, so one-cycle strobes are never missed
  always @(posedge clk)
  begin
    n_rel <= n_rel + int'(reload);
    n_prog <= n_prog + int'(nvm_prog);
    n_cfg <= n_cfg + int'(cfg_wr);
  end
  //--------------------------------------------------------------
  // shared tasks
  //--------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one byte that the device must acknowledge
  task automatic send(input logic [7:0] b);
    logic ack;
    mhcs_i2c_host_inst.wr_byte(b, ack);
    chk(16'(ack), 16'h0000);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    mhcs_i2c_host_inst.start();
    send({I2C_DEV_ADDR, 1'b0});
    send(a);
    send(d);
    mhcs_i2c_host_inst.stop();
  endtask
  // pointer write, repeated start, one byte read then nack
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    mhcs_i2c_host_inst.start();
    send({I2C_DEV_ADDR, 1'b0});
    send(a);
    mhcs_i2c_host_inst.start();
    send({I2C_DEV_ADDR, 1'b1});
    mhcs_i2c_host_inst.rd_byte(1'b1, d);
    mhcs_i2c_host_inst.stop();
    chk(16'(d), 16'(exp));
  endtask
  // burst read of two bytes: host acks the first, so the second is prefetched
  task automatic rd_pair(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] d0, d1;
    mhcs_i2c_host_inst.start();
    send({I2C_DEV_ADDR, 1'b0});
    send(a);
    mhcs_i2c_host_inst.start();
    send({I2C_DEV_ADDR, 1'b1});
    mhcs_i2c_host_inst.rd_byte(1'b0, d0);
    mhcs_i2c_host_inst.rd_byte(1'b1, d1);
    mhcs_i2c_host_inst.stop();
    chk(16'(d0), 16'(e0));
    chk(16'(d1), 16'(e1));
  endtask
  // status inputs change just after a rising edge
  task automatic set_flags(input logic t, input logic l, input logic s);
    @(posedge clk);
    #1 thermal = t;
    lp_state = l;
    stall = s;
  endtask
  //--------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------
  task automatic t_reset();
    chk(16'({speed, takeover, lp_block, cfg_we, reload, nvm_prog, cfg_wr}), 16'h0000);
    chk(16'({cfg_addr, cfg_data}), 16'h0000);
    // pin released, output value held low for open drain
    chk(16'({dev_oe_n, dev_sda}), 16'h0002);
  endtask
  task automatic t_speed();
    reg_wr(ADDR_SPEED_HIGH, 8'hFF); // msb register first
    chk(16'(takeover), 16'h0001);
    chk(16'(speed), 16'h0000); // msb alone leaves the command
    reg_rd(ADDR_SPEED_HIGH, 8'h81);
    reg_wr(ADDR_SPEED_LOW, 8'hA5);
    chk(16'(speed), 16'h01A5);
    reg_wr(ADDR_SPEED_HIGH, 8'h00);
    chk(16'({takeover, speed}), 16'h01A5);
    reg_wr(ADDR_SPEED_LOW, 8'h3C);
    chk(16'(speed), 16'h003C);
    reg_rd(ADDR_SPEED_LOW, 8'h3C);
  endtask
  task automatic t_nvm();
    p0 = n_prog;
    r0 = n_rel;
    reg_wr(ADDR_NVM_CTRL, 8'hFF); // program bit without key
    chk(16'({lp_block, cfg_we}), 16'h0003);
    chk(16'(n_rel - r0), 16'h0001);
    chk(16'(n_prog - p0), 16'h0000);
    reg_rd(ADDR_NVM_CTRL, 8'hC0);
    // key and program bit back to back in one burst
    mhcs_i2c_host_inst.start();
    send({I2C_DEV_ADDR, 1'b0});
    send(ADDR_UNLOCK);
    send(PROGRAM_KEY);
    send(8'h50);
    mhcs_i2c_host_inst.stop();
    chk(16'(n_prog - p0), 16'h0001);
    // a completed read, then a data write, break the sequence
    reg_wr(ADDR_UNLOCK, PROGRAM_KEY);
    reg_rd(ADDR_UNLOCK, PROGRAM_KEY);
    reg_wr(ADDR_NVM_CTRL, 8'h50);
    reg_rd(ADDR_UNLOCK, KEY_RST);
    reg_wr(ADDR_UNLOCK, PROGRAM_KEY);
    reg_wr(ADDR_SPEED_HIGH, 8'h00);
    reg_wr(ADDR_NVM_CTRL, 8'h50);
    chk(16'(n_prog - p0), 16'h0001); // stale key gives no pulse
    chk(16'(lp_block), 16'h0000);
  endtask
  task automatic t_cfg();
    c0 = n_cfg;
    reg_wr(8'h25, 8'hE4);
    chk(16'(n_cfg - c0), 16'h0001);
    chk(16'({cfg_addr, cfg_data}), 16'h25E4);
    reg_wr(ADDR_NVM_CTRL, 8'h00);
    reg_wr(ADDR_CFG_FIRST, 8'h4A);
    chk(16'(n_cfg - c0), 16'h0001); // write refused when disabled
    chk(16'({cfg_we, cfg_addr}), 16'h0020);
  endtask
  task automatic t_status();
    set_flags(1'b1, 1'b0, 1'b0);
    @(posedge clk);
    #1 oc = 1'b1;
    @(posedge clk);
    #1 oc = 1'b0;
    reg_rd(ADDR_STATUS, 8'hA0); // flag held after the pulse
    @(posedge clk);
    #1 oc = 1'b1;
    @(posedge clk);
    #1 oc = 1'b0;
    // empty offset then status, loaded by prefetch after the host ack
    rd_pair(8'h0F, 8'h00, 8'hA0);
    set_flags(1'b0, 1'b1, 1'b0);
    reg_rd(ADDR_STATUS, 8'h40); // cleared by the previous read
    set_flags(1'b0, 1'b0, 1'b1);
    reg_rd(ADDR_STATUS, 8'h10);
  endtask
  //--------------------------------------------------------------
  // main sequence and hang guard
  //--------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    // keep every pin change off the sampling edge
    #1;
    t_reset();
    t_speed();
    t_nvm();
    t_cfg();
    t_status();
    test_done();
  end
  // far above the run length; a hang counts as a mismatch
  initial
  begin
    #1ms;
    n_errors++;
    test_done();
  end
endmodule // mhcs_regs_top_tb_top
